//--- wsde_core.sv
// Purpose: Decode and execute word store instructions into memory writes
// Assumes: Memory port and APB run on clk_sys; register file loaded over APB
// Notes: Undefined, unpredictable and redirected forms write nothing
`timescale 1ns/1ps
`default_nettype none
module wsde_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wsde_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_valid,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_data,
  output logic mem_aligned,
  input wire logic mem_ready
);
  import wsde_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [4:0] count_bits(input logic [15:0] m);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 16; i++) begin
      c = c + {4'h0, m[i]};
    end
    return c;
  endfunction

  function automatic logic [3:0] lowest_bit(input logic [15:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        r = i[3:0];
      end
    end
    return r;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [31:0] gpr [16];
  logic [31:0] instr_reg;
  logic cond_reg;
  logic [ST_WIDTH-1:0] status_reg;
  wsde_state_t state_reg;
  logic [15:0] mask_reg;
  logic [31:0] addr_reg;
  logic [31:0] wb_val_reg;
  logic [3:0] wb_idx_reg;
  logic wb_en_reg;
  logic [31:0] single_data_reg;

  // ****************************************
  // APB decode
  // ****************************************
  wire logic setup_ph = psel & ~penable & ~pready;
  wire logic access = psel & penable & pready;
  wire logic hit_ctrl = (paddr == OFF_CTRL);
  wire logic hit_instr = (paddr == OFF_INSTR);
  wire logic hit_status = (paddr == OFF_STATUS);
  wire logic hit_gpr = (paddr[7:6] == GPR_PAGE) & (paddr[1:0] == 2'h0);
  wire logic mapped = hit_ctrl | hit_instr | hit_status | hit_gpr;
  wire logic [3:0] gpr_sel = paddr[5:2];
  wire logic idle = (state_reg == S_IDLE);
  // Writes to instruction and registers are ignored while busy
  wire logic wr_ok = access & pwrite & idle;
  wire logic go = wr_ok & hit_ctrl & pwdata[CTRL_GO];
  wire logic [31:0] rd_data = hit_ctrl ? {30'h0, cond_reg, 1'b0} :
                              hit_instr ? instr_reg :
                              hit_status ? {24'h0, status_reg} :
                              hit_gpr ? gpr[gpr_sel] : 32'h0;

  // ****************************************
  // Instruction decode
  // ****************************************
  wire logic [15:0] hw1 = instr_reg[31:16];
  wire logic [15:0] hw2 = instr_reg[15:0];
  wire logic is_stm16 = (hw1[15:11] == OP_STM16);
  wire logic is_stm32 = (hw1[15:6] == OP_STM32) & ~hw1[4];
  wire logic is_mdesc = (hw1[15:6] == OP_MDESC) & ~hw1[4];
  wire logic is_imm1 = (hw1[15:11] == OP_IMM1);
  wire logic is_sp_imm = (hw1[15:11] == OP_SP_IMM);
  wire logic is_imm3 = (hw1[15:4] == OP_IMM3);
  wire logic is_wide = (hw1[15:4] == OP_WIDE);
  wire logic is_imm4 = is_wide & hw2[11];
  wire logic is_reg2 = is_wide & (hw2[11:6] == 6'h00);
  wire logic is_reg1 = (hw1[15:9] == OP_REG1);
  wire logic is_multi = is_stm16 | is_stm32 | is_mdesc;
  wire logic is_single = is_imm1 | is_sp_imm | is_imm3 | is_imm4 | is_reg1 | is_reg2;
  wire logic is_narrow = is_imm1 | is_reg1;
  wire logic [3:0] rn32 = hw1[3:0];
  wire logic [3:0] rt32 = hw2[15:12];
  wire logic p_bit = hw2[10];
  wire logic u_bit = hw2[9];
  wire logic w_bit = hw2[8];
  wire logic [7:0] byte_off = hw2[7:0];

  wire logic [15:0] mask_wide = {1'b0, hw2[14], 1'b0, hw2[12:0]};
  wire logic [15:0] mask = is_stm16 ? {8'h00, hw1[7:0]} : mask_wide;
  wire logic [3:0] m_base = is_stm16 ? {1'b0, hw1[10:8]} : rn32;
  wire logic m_wback = is_stm16 | hw1[5];
  wire logic [4:0] m_cnt = count_bits(mask);
  wire logic [31:0] m_bytes = {25'h0, m_cnt, 2'h0};
  wire logic m_base_in = mask[m_base];
  wire logic m_base_low = (lowest_bit(mask) == m_base);
  wire logic m_push = is_mdesc & hw1[5] & (rn32 == IDX_SP);
  wire logic m_unpred = is_stm16 ? (m_cnt == 5'h00) :
                        ((rn32 == IDX_PC) | (m_cnt < 5'h02) | (m_wback & m_base_in));
  wire logic m_base_unk = is_stm16 & m_base_in & ~m_base_low;

  wire logic [3:0] s_base = is_sp_imm ? IDX_SP : is_narrow ? {1'b0, hw1[5:3]} : rn32;
  wire logic [3:0] s_src = is_sp_imm ? {1'b0, hw1[10:8]} : is_narrow ? {1'b0, hw1[2:0]} : rt32;
  wire logic [3:0] s_moff = is_reg1 ? {1'b0, hw1[8:6]} : hw2[3:0];
  wire logic [1:0] s_shift = is_reg1 ? 2'h0 : hw2[5:4];
  wire logic [31:0] reg_off = gpr[s_moff] << s_shift;
  wire logic [31:0] imm_off = is_imm1 ? {25'h0, hw1[10:6], 2'h0} :
                              is_sp_imm ? {22'h0, hw1[7:0], 2'h0} :
                              is_imm3 ? {20'h0, hw2[11:0]} : {24'h0, byte_off};
  wire logic [31:0] s_off = (is_reg1 | is_reg2) ? reg_off : imm_off;
  wire logic s_index = ~is_imm4 | p_bit;
  wire logic s_add = ~is_imm4 | u_bit;
  wire logic s_wback = is_imm4 & w_bit;
  wire logic [31:0] s_base_val = gpr[s_base];
  wire logic [31:0] s_off_addr = s_add ? s_base_val + s_off : s_base_val - s_off;
  wire logic [31:0] s_addr = s_index ? s_off_addr : s_base_val;

  wire logic s_unpriv = is_imm4 & p_bit & u_bit & ~w_bit;
  wire logic s_push = is_imm4 & (rn32 == IDX_SP) & p_bit & ~u_bit & w_bit &
                      (byte_off == PUSH_OFFSET);
  wire logic wide_ones = (is_imm3 | is_wide) & (rn32 == IDX_PC);
  wire logic s_undef = wide_ones | (is_imm4 & ~p_bit & ~w_bit) | (is_wide & ~is_imm4 & ~is_reg2);
  wire logic s_unpred = ((is_imm3 | is_imm4 | is_reg2) & (rt32 == IDX_PC)) |
                        (s_wback & (rn32 == rt32)) |
                        (is_reg2 & ((hw2[3:0] == IDX_SP) | (hw2[3:0] == IDX_PC)));

  wire logic d_undef = ~(is_multi | is_single) | (is_single & ~s_unpriv & ~s_push & s_undef);
  wire logic d_redirect = m_push | s_unpriv | s_push;
  wire logic d_unpred = is_multi ? m_unpred : s_unpred;
  wire logic d_run = ~d_undef & ~d_redirect & ~d_unpred;

  // ****************************************
  // Execute sequencing
  // ****************************************
  wire logic [3:0] low_idx = lowest_bit(mask_reg);
  wire logic beat_done = mem_valid & mem_ready;
  wire logic [15:0] mask_after = mask_reg & ~(16'h0001 << low_idx);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      prdata <= setup_ph & ~pwrite ? rd_data : 32'h0;
      pslverr <= setup_ph & ~mapped;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      instr_reg <= 32'h0;
      cond_reg <= 1'b0;
    end else if (wr_ok & hit_instr) begin
      instr_reg <= pwdata;
    end else if (wr_ok & hit_ctrl) begin
      cond_reg <= pwdata[CTRL_COND];
    end
  end

  // Memory writes and flag capture; one idle cycle between beats keeps timing simple
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      status_reg <= '0;
      mask_reg <= 16'h0;
      addr_reg <= 32'h0;
      wb_val_reg <= 32'h0;
      wb_idx_reg <= 4'h0;
      wb_en_reg <= 1'b0;
      single_data_reg <= 32'h0;
      mem_valid <= 1'b0;
      mem_addr <= 32'h0;
      mem_data <= 32'h0;
      mem_aligned <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (go) begin
            status_reg <= '0;
            status_reg[ST_DONE] <= ~cond_reg | ~d_run;
            status_reg[ST_BUSY] <= cond_reg & d_run;
            status_reg[ST_SKIP] <= ~cond_reg;
            status_reg[ST_UNDEF] <= cond_reg & d_undef;
            status_reg[ST_UNPRED] <= cond_reg & ~d_undef & ~d_redirect & d_unpred;
            status_reg[ST_PUSH] <= cond_reg & (m_push | s_push);
            status_reg[ST_UNPRIV] <= cond_reg & s_unpriv;
            status_reg[ST_BASE_UNK] <= cond_reg & d_run & is_multi & m_base_unk;
            mask_reg <= mask;
            if (is_multi) begin
              wb_idx_reg <= m_base;
              wb_en_reg <= m_wback;
              addr_reg <= is_mdesc ? gpr[m_base] - m_bytes : gpr[m_base];
              wb_val_reg <= is_mdesc ? gpr[m_base] - m_bytes : gpr[m_base] + m_bytes;
            end else begin
              wb_idx_reg <= s_base;
              wb_en_reg <= s_wback;
              addr_reg <= s_addr;
              wb_val_reg <= s_off_addr;
              single_data_reg <= gpr[s_src];
            end
            if (cond_reg & d_run) begin
              state_reg <= is_multi ? S_MULTI : S_SINGLE;
            end
          end
        end
        S_MULTI: begin
          if (!mem_valid) begin
            mem_valid <= 1'b1;
            mem_addr <= addr_reg;
            mem_data <= gpr[low_idx];
            mem_aligned <= 1'b1;
          end else if (beat_done) begin
            mem_valid <= 1'b0;
            mask_reg <= mask_after;
            addr_reg <= addr_reg + WORD_BYTES;
            if (mask_after == 16'h0) begin
              state_reg <= S_WBACK;
            end
          end
        end
        S_SINGLE: begin
          if (!mem_valid) begin
            mem_valid <= 1'b1;
            mem_addr <= addr_reg;
            mem_data <= single_data_reg;
            mem_aligned <= 1'b0;
          end else if (beat_done) begin
            mem_valid <= 1'b0;
            state_reg <= S_WBACK;
          end
        end
        S_WBACK: begin
          status_reg[ST_BUSY] <= 1'b0;
          status_reg[ST_DONE] <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Register file: software loads while idle, base update at end of execution
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        gpr[i] <= 32'h0;
      end
    end else if ((state_reg == S_WBACK) && wb_en_reg) begin
      gpr[wb_idx_reg] <= wb_val_reg;
    end else if (wr_ok & hit_gpr) begin
      gpr[gpr_sel] <= pwdata;
    end
  end
endmodule
`default_nettype wire

//--- wsde_pkg.sv
// Purpose: Constants for the word store decode and execute block
// Assumes: Instruction word holds first halfword in [31:16], second in [15:0]
// Notes: Register map is reached over APB, one aligned word per register
// ****************************************
// How it works
// - Lowest-indexed selected register goes to lowest address, rising upward.
// - Ascending multiple store keeps base unless write-back; then base updated afterwards.
// - Narrow ascending store with base in list, not lowest: its stored value is unknown.
// - Descending store with write-back and stack-pointer base decodes as push.
// - Descending mask: bit15 zero, bit14 link slot, bit13 zero, bits12-0 list.
// - Descending store unpredictable for base 15 or under two mask bits.
// - Descending store unpredictable when write-back and base bit set in mask.
// - Descending start is base minus 4 times count; ascending words; base reduced on write-back.
// - Short immediate form: five-bit field times four, added, no write-back.
// - Stack form: base 13, eight-bit field times four, added, no write-back.
// - Wide immediate: base all ones undefined, source 15 unpredictable, offset 0-4095.
// - Indexed form redirects P1U1W0 to unprivileged store, SP push pattern to push.
// - Indexed form undefined for base ones or P=W=0; unpredictable cases flagged.
// - Offset address is base plus or minus offset; index selects; write-back stores it.
// - Immediate single stores write full source word as unaligned four-byte access.
// - Register offset shifted left 0-3, added to base, no base update.
// - Narrow register-offset form uses a shift of zero.
// - Wide register-offset: source 15 or offset 13/15 unpredictable; base ones undefined.
// ****************************************
package wsde_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [1:0] GPR_PAGE = 2'h1;
  localparam int CTRL_GO = 0;
  localparam int CTRL_COND = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_UNDEF = 2;
  localparam int ST_UNPRED = 3;
  localparam int ST_BASE_UNK = 4;
  localparam int ST_PUSH = 5;
  localparam int ST_UNPRIV = 6;
  localparam int ST_SKIP = 7;
  localparam int ST_WIDTH = 8;
  localparam logic [3:0] IDX_SP = 4'hd;
  localparam logic [3:0] IDX_PC = 4'hf;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [7:0] PUSH_OFFSET = 8'h04;
  localparam logic [4:0] OP_STM16 = 5'h18;
  localparam logic [9:0] OP_STM32 = 10'h3a2;
  localparam logic [9:0] OP_MDESC = 10'h3a4;
  localparam logic [4:0] OP_IMM1 = 5'h0c;
  localparam logic [4:0] OP_SP_IMM = 5'h12;
  localparam logic [11:0] OP_IMM3 = 12'hf8c;
  localparam logic [11:0] OP_WIDE = 12'hf84;
  localparam logic [6:0] OP_REG1 = 7'h28;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_MULTI = 4'h2,
    S_SINGLE = 4'h4,
    S_WBACK = 4'h8
  } wsde_state_t;
endpackage

//--- wsde_core_checker.sv
// Purpose: Port checks for the word store core
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only APB and memory port signals
`timescale 1ns/1ps
`default_nettype none
module wsde_core_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_data,
  input wire logic mem_aligned,
  input wire logic mem_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ********
  // Memory port and APB timing
  // ********
  mem_hold_a: assert property (mem_valid && !mem_ready |=> mem_valid && $stable({mem_addr, mem_data, mem_aligned}))
    else $error("memory request changed before acceptance");
  beat_gap_a: assert property (mem_valid && mem_ready |=> !mem_valid) else $error("no gap after accepted beat");
  word_align_a: assert property (mem_valid && mem_aligned |-> mem_addr[1:0] == 2'h0) else $error("unaligned word");
  addr_step_a: assert property (mem_valid && mem_ready && mem_aligned ##1 !mem_valid ##1 mem_valid |->
    mem_aligned && mem_addr == $past(mem_addr, 2) + 32'h4) else $error("multiple store address not ascending by four");
  single_gap_a: assert property (mem_valid && mem_ready && !mem_aligned |=> !mem_valid [*3])
    else $error("single store wrote more than one word");
  zero_wait_a: assert property (psel && !penable ##1 psel && penable |-> pready) else $error("pready late");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero outside answer");
endmodule
bind wsde_core wsde_core_checker i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_valid(mem_valid), .mem_addr(mem_addr),
  .mem_data(mem_data), .mem_aligned(mem_aligned), .mem_ready(mem_ready));
`default_nettype wire

//--- wsde_mem_model.sv
// Purpose: Memory system model taking word writes
// Assumes: Same clock as the core
// Notes: Stall count is set by the bench between instructions
`timescale 1ns/1ps
`default_nettype none
module wsde_mem_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_data,
  input wire logic mem_aligned,
  input wire logic [1:0] stall,
  output logic mem_ready
);
  // ********
  // Accept after a stall, log every beat
  // ********
  logic [1:0] wait_cnt = 2'h0;
  logic [64:0] q_w[$];
  assign mem_ready = mem_valid && (wait_cnt == stall);
  always @(posedge clk_sys) begin
    wait_cnt <= (!rst_n || !mem_valid || mem_ready) ? 2'h0 : wait_cnt + 2'h1;
    if (rst_n && mem_valid && mem_ready) q_w.push_back({mem_aligned, mem_addr, mem_data});
  end
endmodule
`default_nettype wire

//--- test_word_store_decode_execute.sv
// Purpose: Self-checking bench for the word store core
// Assumes: Skip status bit in a row means condition failed
// Notes: GPRs reloaded per row so write-back never leaks between rows
`timescale 1ns/1ps
`default_nettype none
module test_word_store_decode_execute;
  import wsde_pkg::*;
  typedef struct {logic [31:0] ins; logic [15:0] m; logic [31:0] a; logic [7:0] s; logic [3:0] b; logic [31:0] v;} wsde_row_t;
  logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata, mem_addr, mem_data;
  logic pready, pslverr, mem_valid, mem_aligned, mem_ready;
  logic [1:0] stall = 2'h0;
  int err_count = 0, checks = 0, k;
  // ********
  // Rows: instruction, written registers, first address, status, base index, base after
  // ********
  wsde_row_t rows [27] = '{
    '{32'h60d1_0000, 16'h0002, 32'h120c, 8'h02, 4'h2, 32'h1200},
    '{32'h93ff_0000, 16'h0008, 32'h20fc, 8'h02, 4'hd, 32'h1d00},
    '{32'hf8c4_5fff, 16'h0020, 32'h23ff, 8'h02, 4'h4, 32'h1400},
    '{32'hf846_7910, 16'h0080, 32'h1600, 8'h02, 4'h6, 32'h15f0},
    '{32'hf846_7f20, 16'h0080, 32'h1620, 8'h02, 4'h6, 32'h1620},
    '{32'h509c_0000, 16'h0010, 32'h2500, 8'h02, 4'h3, 32'h1300},
    '{32'hf841_5032, 16'h0020, 32'ha100, 8'h02, 4'h1, 32'h1100},
    '{32'he928_400a, 16'h400a, 32'h17f4, 8'h02, 4'h8, 32'h17f4},
    '{32'he902_0011, 16'h0011, 32'h11f8, 8'h02, 4'h2, 32'h1200},
    '{32'he889_0024, 16'h0024, 32'h1900, 8'h02, 4'h9, 32'h1900},
    '{32'hc10c_0000, 16'h000c, 32'h1100, 8'h02, 4'h1, 32'h1108},
    '{32'hc30a_0000, 16'h000a, 32'h1300, 8'h12, 4'h3, 32'h1308},
    '{32'h60d1_0000, 16'h0000, 32'h0000, 8'h82, 4'h2, 32'h1200},
    '{32'he92d_4006, 16'h0000, 32'h0000, 8'h22, 4'hd, 32'h1d00},
    '{32'he90f_0006, 16'h0000, 32'h0000, 8'h0a, 4'hf, 32'h1f00},
    '{32'he922_0006, 16'h0000, 32'h0000, 8'h0a, 4'h2, 32'h1200},
    '{32'hf8cf_5004, 16'h0000, 32'h0000, 8'h06, 4'hf, 32'h1f00},
    '{32'hf846_7e20, 16'h0000, 32'h0000, 8'h42, 4'h6, 32'h1600},
    '{32'hf84d_7d04, 16'h0000, 32'h0000, 8'h22, 4'hd, 32'h1d00},
    '{32'hf846_7820, 16'h0000, 32'h0000, 8'h06, 4'h6, 32'h1600},
    '{32'hf841_500d, 16'h0000, 32'h0000, 8'h0a, 4'h1, 32'h1100},
    '{32'he8a9_0024, 16'h0024, 32'h1900, 8'h02, 4'h9, 32'h1908},
    '{32'he902_0010, 16'h0000, 32'h0000, 8'h0a, 4'h2, 32'h1200},
    '{32'hf8c4_f010, 16'h0000, 32'h0000, 8'h0a, 4'h4, 32'h1400},
    '{32'hf846_6d04, 16'h0000, 32'h0000, 8'h0a, 4'h6, 32'h1600},
    '{32'hc100_0000, 16'h0000, 32'h0000, 8'h0a, 4'h1, 32'h1100},
    '{32'h0000_0000, 16'h0000, 32'h0000, 8'h06, 4'h0, 32'h1000}};
  always #50 clk_sys = ~clk_sys;
  wsde_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_valid(mem_valid),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_aligned(mem_aligned), .mem_ready(mem_ready));
  wsde_mem_model i_mem (.clk_sys(clk_sys), .rst_n(rst_n), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_aligned(mem_aligned), .stall(stall), .mem_ready(mem_ready));
  function automatic logic [31:0] g(input logic [3:0] i);
    return 32'h1000 + {20'h0, i, 8'h00};
  endfunction
  task automatic cmp(input string n, input logic [64:0] e, input logic [64:0] s);
    checks++;
    if (s !== e) err_count++;
    if (s !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, s);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Answer taken at the rising edge that sees pready; only the watchdog ends a hang
    do @(posedge clk_sys); while (pready !== 1'b1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge clk_sys);
  endtask
  task automatic run(input wsde_row_t r);
    int j;
    logic [31:0] ad;
    for (j = 0; j < 16; j++) apb(1'b1, {GPR_PAGE, 4'(j), 2'h0}, g(4'(j)));
    apb(1'b1, OFF_INSTR, r.ins);
    for (j = 0; j < 2; j++) apb(1'b1, OFF_CTRL, {30'h0, !r.s[ST_SKIP], j[0]});
    j = 0;
    do apb(1'b0, OFF_STATUS, 32'h0); while (rd[ST_DONE] !== 1'b1 && ++j < 40);
    cmp("status", r.s, rd);
    ad = r.a;
    for (j = 0; j < 16; j++) begin
      if (r.m[j]) cmp("write", {$countones(r.m) > 1, ad, g(4'(j))}, i_mem.q_w.pop_front());
      if (r.m[j]) ad += 32'h4;
    end
    cmp("extra writes", 65'h0, 65'(i_mem.q_w.size()));
    apb(1'b0, {GPR_PAGE, r.b, 2'h0}, 32'h0);
    cmp("base", r.v, rd);
  endtask
  task automatic final_report();
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp("reset status", 65'h0, rd);
    apb(1'b0, {GPR_PAGE, 4'h5, 2'h0}, 32'h0);
    cmp("reset gpr", 65'h0, rd);
    apb(1'b0, 8'h30, 32'h0);
    cmp("unmapped", 65'h1_0000_0000, {er, rd});
    // Stall varies so multiple stores also meet a slow memory
    for (k = 0; k < 27; k++) begin
      stall <= 2'(k % 3);
      run(rows[k]);
    end
    // Reset in mid-run while a multiple store waits on a slow memory
    stall <= 2'h2;
    apb(1'b1, OFF_INSTR, rows[7].ins);
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    cmp("mem_valid before reset", 65'h1, 65'(mem_valid));
    @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    cmp("mem_valid after reset", 65'h0, 65'(mem_valid));
    cmp("writes cut by reset", 65'h0, 65'(i_mem.q_w.size()));
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp("status after reset", 65'h0, rd);
    apb(1'b0, {GPR_PAGE, 4'h8, 2'h0}, 32'h0);
    cmp("gpr after reset", 65'h0, rd);
    final_report();
  end
  initial begin
    #3000000 cmp("watchdog", 65'h0, 65'h1);
    final_report();
  end
endmodule
`default_nettype wire
